/* File: bench/cmc_analog_model.sv */
// model of the analog pins and reference that feed both comparators
`default_nettype none

module cmc_analog_model
    import cmc_pkg::*;
(
    input wire logic aclk,
    input wire cmc_route_t route_q,
    input wire logic [7:0][7:0] volt,
    output logic cmp_a_raw,
    output logic cmp_b_raw
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tog_q = 1'b0;
    // a disabled comparator shows a moving level, never a stale one
    always @(posedge aclk) begin
        tog_q <= !tog_q;
    end
    // selector 7 reads volt[7], held at zero by the bench
    always_comb begin
        cmp_a_raw = route_q.en_a ?
            (volt[route_q.a_pos] > volt[route_q.a_neg]) : tog_q;
        cmp_b_raw = route_q.en_b ?
            (volt[route_q.b_pos] > volt[route_q.b_neg]) : !tog_q;
    end
endmodule : cmc_analog_model

`default_nettype wire

/* File: bench/test_dual_comparator_control.sv */
// self-checking bench of the comparator control block
`default_nettype none

module test_dual_comparator_control
    import cmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, cmp_a_raw, cmp_b_raw, cmp_a_pin, cmp_a_pin_en, cmp_b_pin;
    logic cmp_b_pin_en, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rnd;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0][7:0] volt;
    cmc_route_t route_q, er;
    int fail_count, cmp_count, i, k;

    cmc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_a_raw, .cmp_b_raw,
        .route_q, .cmp_a_pin, .cmp_a_pin_en, .cmp_b_pin, .cmp_b_pin_en, .irq);
    cmc_analog_model model (.aclk, .route_q, .volt, .cmp_a_raw, .cmp_b_raw);

    initial begin
        aclk = 1'b0;
        forever #10 aclk = !aclk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // lfsr of the bench; seed 6 keeps every run the same
    function automatic void step();
        rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    endfunction : step

    // mode decode as settled by the designer; selector 7 means no input
    function automatic cmc_route_t exp_rt(input logic [2:0] m, input logic c);
        cmc_route_t r;
        r.en_a = m != 3'h7;
        r.en_b = !(m inside {3'h1, 3'h5, 3'h7});
        r.oe_a = m == 3'h3 || m == 3'h5;
        r.oe_b = m == 3'h3;
        r.a_pos = (m inside {3'h0, 3'h1}) ? 3'h3 : (m inside {3'h2, 3'h3}) ? 3'h2 : 3'h6;
        r.b_pos = (m inside {3'h0, 3'h2, 3'h3}) ? 3'h2 : 3'h6;
        r.a_neg = (m == 3'h6 && c) ? 3'h3 : 3'h0;
        r.b_neg = (m == 3'h6 && c) ? 3'h2 : 3'h1;
        if (!r.en_a) {r.a_pos, r.a_neg} = 6'h3f;
        if (!r.en_b) {r.b_pos, r.b_neg} = 6'h3f;
        return r;
    endfunction : exp_rt

    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) begin
            fail_count++;
            report_and_stop();
        end
    endtask : axw

    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rdat = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) begin
            fail_count++;
            report_and_stop();
        end
    endtask : axr

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        volt = '0;
        rnd = 8'h06;
        fail_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk("pins", {cmp_a_pin, cmp_b_pin, cmp_a_pin_en, cmp_b_pin_en, irq}, 0);
        axr(8'h00);
        chk("ctrl reset", rdat, 32'h07);
        // every mode with both switch settings, random inversion and junk in bits 7:6
        for (i = 0; i < 16; i++) begin
            step();
            d = {16'h0, rnd, rnd[7:4], 4'(i)};
            for (k = 0; k < 7; k++) begin
                step();
                volt[k] <= rnd;
            end
            axw(8'h00, d);
            repeat (3) @(posedge aclk);
            er = exp_rt(d[2:0], d[3]);
            axr(8'h00);
            chk("ctrl", rdat, {24'h0, er.en_b & (cmp_b_raw ^ d[5]),
                er.en_a & (cmp_a_raw ^ d[4]), d[5:0]});
            chk("pin a", 32'(cmp_a_pin), 32'(rdat[6]));
            chk("pin b", 32'(cmp_b_pin), 32'(rdat[7]));
            chk("en", 32'(route_q[15:12]), 32'(er[15:12]));
            chk("pin en", {cmp_a_pin_en, cmp_b_pin_en}, 32'(er[13:12]));
            chk("sel a", 32'(route_q[11:6]), 32'(er[11:6]));
            chk("sel b", 32'(route_q[5:0]), 32'(er[5:0]));
        end
        // switch set outside mode 110, here with mode 000, must leave a_neg on pin 0
        axw(8'h00, 32'h08);
        repeat (2) @(posedge aclk);
        chk("sw ignored", 32'(route_q[8:6]), 32'h0);
        // flag and interrupt, masked in then out
        axw(8'h00, 32'h0);
        axw(8'h08, 32'h1);
        volt[3] <= 8'h10;
        volt[0] <= 8'h20;
        repeat (3) @(posedge aclk);
        axw(8'h04, 32'h1);
        #1;
        chk("irq idle", 32'(irq), 32'h0);
        volt[3] <= 8'h30;
        repeat (3) @(posedge aclk);
        #1;
        chk("irq set", 32'(irq), 32'h1);
        axr(8'h04);
        chk("flag", rdat, 32'h1);
        axw(8'h04, 32'h1);
        axr(8'h04);
        chk("flag clear", {rdat[30:0], irq}, 32'h0);
        axw(8'h08, 32'h0);
        volt[3] <= 8'h10;
        repeat (3) @(posedge aclk);
        axr(8'h04);
        chk("masked", {rdat[30:0], irq}, 32'h2);
        // unmapped places answer an error and change nothing
        axw(8'h0c, 32'h3f);
        chk("wr err", 32'(rs), 32'h2);
        axr(8'h10);
        chk("rd err", {rdat[29:0], rs}, 32'h2);
        axr(8'h00);
        chk("ctrl kept", 32'(rdat[5:0]), 32'h0);
        report_and_stop();
    end
endmodule : test_dual_comparator_control

`default_nettype wire

/* File: verilog/cmc_axil_slave.sv */
// axi4-lite slave front end of the comparator control block
`default_nettype none
`include "cmc_map.svh"

module cmc_axil_slave
    import cmc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`CMC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CMC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output cmc_wr_t wr_req,
    input wire logic wr_err,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    logic [`CMC_ADDR_W-1:0] addr_q;
    logic [31:0] data_q;
    logic [3:0] strb_q;

    // address and data are held until both are in; ready low means held
    assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_req = '{addr: addr_q, data: data_q, strb: strb_q};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            addr_q <= s_axi_awaddr;
        end else if (wr_en) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            data_q <= '0;
            strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            data_q <= s_axi_wdata;
            strb_q <= s_axi_wstrb;
        end else if (wr_en) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CMC_RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `CMC_RESP_SLVERR : `CMC_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // reads have no side effects, so data is sampled at the address edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CMC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `CMC_RESP_SLVERR : `CMC_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : cmc_axil_slave

`default_nettype wire

/* File: verilog/cmc_irq_bits.sv */
// sticky event flags with mask and one level interrupt
`default_nettype none

module cmc_irq_bits #(
    parameter int N = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] event_set,
    input wire logic [N-1:0] clear_ones,
    input wire logic [N-1:0] mask,
    output logic [N-1:0] status_q,
    output logic irq_q
);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            // a set in the clearing cycle wins, so no event is lost
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    status_q[i] <= 1'b0;
                end else if (event_set[i]) begin
                    status_q[i] <= 1'b1;
                end else if (clear_ones[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask);
        end
    end

endmodule : cmc_irq_bits

`default_nettype wire

/* File: verilog/cmc_map.svh */
// offsets, field positions, reset values and codes of the comparator control block
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CMC_ADDR_W 8
`define CMC_CTRL_OFFSET 8'h00
`define CMC_STATUS_OFFSET 8'h04
`define CMC_MASK_OFFSET 8'h08

// ****************************************************************
// control register fields
// ****************************************************************
`define CMC_RES_B_BIT 7
`define CMC_RES_A_BIT 6
`define CMC_INV_B_BIT 5
`define CMC_INV_A_BIT 4
`define CMC_SWITCH_BIT 3
`define CMC_CFG_MSB 2
`define CMC_CFG_LSB 0
`define CMC_CTRL_RESET 8'h07
`define CMC_FLAG_BIT 0

// ****************************************************************
// configuration field codes
// ****************************************************************
`define CMC_CFG_INDEP 3'h0
`define CMC_CFG_SINGLE 3'h1
`define CMC_CFG_COMMON 3'h2
`define CMC_CFG_COMMON_OUT 3'h3
`define CMC_CFG_REF 3'h4
`define CMC_CFG_REF_SINGLE 3'h5
`define CMC_CFG_SWITCHED 3'h6
`define CMC_CFG_OFF 3'h7

// ****************************************************************
// input selector codes: analog pins 0..3, reference, none
// ****************************************************************
`define CMC_SEL_AN0 3'h0
`define CMC_SEL_AN1 3'h1
`define CMC_SEL_AN2 3'h2
`define CMC_SEL_AN3 3'h3
`define CMC_SEL_REF 3'h6
`define CMC_SEL_NONE 3'h7

// ****************************************************************
// bus answers
// ****************************************************************
`define CMC_RESP_OKAY 2'h0
`define CMC_RESP_SLVERR 2'h2

`endif

/* File: verilog/cmc_pkg.sv */
// types shared by the comparator control block
`default_nettype none

package cmc_pkg;

    // ****************************************************************
    // control register image
    // ****************************************************************
    typedef struct packed {
        logic result_b;
        logic result_a;
        logic invert_b;
        logic invert_a;
        logic input_switch;
        logic [2:0] config_field;
    } cmc_ctrl_t;

    // ****************************************************************
    // analog routing handed to the comparator circuits
    // ****************************************************************
    typedef struct packed {
        logic en_a;
        logic en_b;
        logic oe_a;
        logic oe_b;
        logic [2:0] a_pos;
        logic [2:0] a_neg;
        logic [2:0] b_pos;
        logic [2:0] b_neg;
    } cmc_route_t;

    // ****************************************************************
    // register write request
    // ****************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } cmc_wr_t;

endpackage : cmc_pkg

`default_nettype wire

/* File: verilog/cmc_top.sv */
// comparator control and status block with axi4-lite registers
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
`include "cmc_map.svh"

module cmc_top
    import cmc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`CMC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CMC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp_a_raw,
    input wire logic cmp_b_raw,
    output cmc_route_t route_q,
    output logic cmp_a_pin,
    output logic cmp_a_pin_en,
    output logic cmp_b_pin,
    output logic cmp_b_pin_en,
    output logic irq
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic wr_en;
    cmc_wr_t wr_req;
    logic wr_err;
    logic [31:0] rd_data;
    logic rd_err;
    cmc_ctrl_t ctrl_q;
    cmc_route_t route_d;
    logic cmp_a_result_q;
    logic cmp_a_result_d;
    logic cmp_b_result_q;
    logic cmp_b_result_d;
    logic change_evt;
    logic [0:0] flag_clear;
    logic [0:0] mask_q;
    logic [0:0] status_q;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;

    // ****************************************************************
    // bus slave
    // ****************************************************************
    cmc_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_req(wr_req),
        .wr_err(wr_err),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ****************************************************************
    // address decode
    // ****************************************************************
    // only byte lane 0 carries register bits; other lanes are ignored
    assign wr_ctrl = wr_en && wr_req.addr == `CMC_CTRL_OFFSET && wr_req.strb[0];
    assign wr_status = wr_en && wr_req.addr == `CMC_STATUS_OFFSET && wr_req.strb[0];
    assign wr_mask = wr_en && wr_req.addr == `CMC_MASK_OFFSET && wr_req.strb[0];
    assign wr_err = !(wr_req.addr == `CMC_CTRL_OFFSET || wr_req.addr == `CMC_STATUS_OFFSET
                      || wr_req.addr == `CMC_MASK_OFFSET);

    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        unique case (s_axi_araddr)
            `CMC_CTRL_OFFSET: begin
                rd_data[7:0] = ctrl_q;
            end
            `CMC_STATUS_OFFSET: begin
                rd_data[0:0] = status_q;
            end
            `CMC_MASK_OFFSET: begin
                rd_data[0:0] = mask_q;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    // result bits load every cycle from the comparators; writes never touch them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= cmc_ctrl_t'(`CMC_CTRL_RESET);
        end else begin
            ctrl_q.result_b <= cmp_b_result_d;
            ctrl_q.result_a <= cmp_a_result_d;
            if (wr_ctrl) begin
                ctrl_q.invert_b <= wr_req.data[`CMC_INV_B_BIT];
                ctrl_q.invert_a <= wr_req.data[`CMC_INV_A_BIT];
                ctrl_q.input_switch <= wr_req.data[`CMC_SWITCH_BIT];
                ctrl_q.config_field <= wr_req.data[`CMC_CFG_MSB:`CMC_CFG_LSB];
            end
        end
    end

    // ****************************************************************
    // input routing per configuration
    // ****************************************************************
    function automatic cmc_route_t route_of(input logic [2:0] cfg, input logic sw);
        cmc_route_t r;
        r = '{en_a: 1'b1, en_b: 1'b1, oe_a: 1'b0, oe_b: 1'b0,
              a_pos: `CMC_SEL_AN3, a_neg: `CMC_SEL_AN0,
              b_pos: `CMC_SEL_AN2, b_neg: `CMC_SEL_AN1};
        unique case (cfg)
            `CMC_CFG_INDEP: begin
            end
            `CMC_CFG_SINGLE: begin
                r.en_b = 1'b0;
                r.b_pos = `CMC_SEL_NONE;
                r.b_neg = `CMC_SEL_NONE;
            end
            `CMC_CFG_COMMON: begin
                r.a_pos = `CMC_SEL_AN2;
            end
            `CMC_CFG_COMMON_OUT: begin
                r.a_pos = `CMC_SEL_AN2;
                r.oe_a = 1'b1;
                r.oe_b = 1'b1;
            end
            `CMC_CFG_REF: begin
                r.a_pos = `CMC_SEL_REF;
                r.b_pos = `CMC_SEL_REF;
            end
            `CMC_CFG_REF_SINGLE: begin
                r.a_pos = `CMC_SEL_REF;
                r.oe_a = 1'b1;
                r.en_b = 1'b0;
                r.b_pos = `CMC_SEL_NONE;
                r.b_neg = `CMC_SEL_NONE;
            end
            `CMC_CFG_SWITCHED: begin
                r.a_pos = `CMC_SEL_REF;
                r.b_pos = `CMC_SEL_REF;
                r.a_neg = sw ? `CMC_SEL_AN3 : `CMC_SEL_AN0;
                r.b_neg = sw ? `CMC_SEL_AN2 : `CMC_SEL_AN1;
            end
            `CMC_CFG_OFF: begin
                // off saves power until software picks a mode
                r = '{en_a: 1'b0, en_b: 1'b0, oe_a: 1'b0, oe_b: 1'b0,
                      a_pos: `CMC_SEL_NONE, a_neg: `CMC_SEL_NONE,
                      b_pos: `CMC_SEL_NONE, b_neg: `CMC_SEL_NONE};
            end
        endcase
        return r;
    endfunction : route_of

    assign route_d = route_of(ctrl_q.config_field, ctrl_q.input_switch);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_q <= route_of(`CMC_CFG_OFF, 1'b0);
        end else begin
            route_q <= route_d;
        end
    end

    // ****************************************************************
    // results, polarity and pins
    // ****************************************************************
    // a disabled comparator reads low whatever its inversion bit says
    assign cmp_a_result_d = route_d.en_a && (cmp_a_raw ^ ctrl_q.invert_a);
    assign cmp_b_result_d = route_d.en_b && (cmp_b_raw ^ ctrl_q.invert_b);

    // the result flops are the read-only bits of the control register
    assign cmp_a_result_q = ctrl_q.result_a;
    assign cmp_b_result_q = ctrl_q.result_b;

    // pins load from the same value as the register bits, so neither lags the other
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_a_pin <= 1'b0;
            cmp_b_pin <= 1'b0;
            cmp_a_pin_en <= 1'b0;
            cmp_b_pin_en <= 1'b0;
        end else begin
            cmp_a_pin <= cmp_a_result_d;
            cmp_b_pin <= cmp_b_result_d;
            cmp_a_pin_en <= route_d.oe_a;
            cmp_b_pin_en <= route_d.oe_b;
        end
    end

    // ****************************************************************
    // change flag and interrupt
    // ****************************************************************
    // flag rises at the same edge as the changed result
    assign change_evt = (cmp_a_result_d != cmp_a_result_q)
                        || (cmp_b_result_d != cmp_b_result_q);
    assign flag_clear = wr_status ? wr_req.data[`CMC_FLAG_BIT:`CMC_FLAG_BIT] : 1'b0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= '0;
        end else if (wr_mask) begin
            mask_q <= wr_req.data[`CMC_FLAG_BIT:`CMC_FLAG_BIT];
        end
    end

    cmc_irq_bits #(
        .N(1)
    ) u_irq (
        .aclk(aclk),
        .aresetn(aresetn),
        .event_set(change_evt),
        .clear_ones(flag_clear),
        .mask(mask_q),
        .status_q(status_q),
        .irq_q(irq)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_result_moved;
        $changed(cmp_a_result_q) || $changed(cmp_b_result_q);
    endsequence

    sequence s_ctrl_write;
        wr_ctrl ##1 1'b1;
    endsequence

    sequence s_flag_cleared;
        wr_status && wr_req.data[`CMC_FLAG_BIT] && !change_evt;
    endsequence

    a_reset_values: assert property (disable iff (1'b0)
        !aresetn |=> (ctrl_q == cmc_ctrl_t'(`CMC_CTRL_RESET)) && !irq)
        else $error("control register not at reset value after reset");

    a_b_polarity: assert property (route_d.en_b |=>
        cmp_b_result_q == ($past(cmp_b_raw) ^ $past(ctrl_q.invert_b)))
        else $error("comparator b result polarity wrong");

    a_a_polarity: assert property (route_d.en_a |=>
        cmp_a_result_q == ($past(cmp_a_raw) ^ $past(ctrl_q.invert_a)))
        else $error("comparator a result polarity wrong");

    a_off_low: assert property (ctrl_q.config_field == `CMC_CFG_OFF |=>
        !cmp_a_result_q && !cmp_b_result_q && !cmp_a_pin && !cmp_b_pin
        && !route_q.en_a && !route_q.en_b)
        else $error("off mode did not force comparators low");

    a_switch_route: assert property (
        ctrl_q.config_field == `CMC_CFG_SWITCHED && ctrl_q.input_switch |=>
        route_q.a_neg == `CMC_SEL_AN3 && route_q.b_neg == `CMC_SEL_AN2)
        else $error("input switch did not route pins 3 and 2");

    a_switch_ignored: assert property (
        ctrl_q.config_field != `CMC_CFG_SWITCHED && $changed(ctrl_q.input_switch)
        && $stable(ctrl_q.config_field) |=> $stable(route_q))
        else $error("input switch acted outside switched mode");

    a_pin_matches: assert property (cmp_a_pin == ctrl_q.result_a
        && cmp_b_pin == ctrl_q.result_b)
        else $error("pin and readable result disagree");

    a_change_flag: assert property (s_result_moved |->
        status_q[0] ##1 irq == $past(mask_q[0]))
        else $error("result change did not set the flag");

    a_ctrl_write: assert property (wr_ctrl |=>
        ctrl_q.config_field == $past(wr_req.data[2:0])
        && ctrl_q.invert_b == $past(wr_req.data[5])
        && ctrl_q.invert_a == $past(wr_req.data[4]))
        else $error("control write not stored");

    a_ctrl_settles: assert property (s_ctrl_write |=>
        route_q == route_of($past(wr_req.data[2:0], 2), $past(wr_req.data[3], 2)))
        else $error("routing did not follow written mode");

    a_flag_sticky: assert property (status_q[0] && !flag_clear[0] |=> status_q[0])
        else $error("change flag dropped without a clear");

    a_flag_clear: assert property (s_flag_cleared |=> !status_q[0])
        else $error("change flag not cleared by writing one");

    a_irq_level: assert property (irq == $past(status_q[0] && mask_q[0]))
        else $error("interrupt does not follow unmasked flag");

    a_pin_drive: assert property (route_d.oe_a |=> cmp_a_pin_en)
        else $error("pin a not driven in an output mode");

endmodule : cmc_top

`default_nettype wire
